// *** e1_sa_pkg.sv ***
// shared constants and types for the e1 spare/international overhead bit access, plus its shift-capture leaf
`timescale 1ns/100ps

package e1_sa_pkg;
  // -----------------------------------------------------------------
  // status bit positions in framing_status_four
  // -----------------------------------------------------------------
  localparam int SR4_RX_ALIGN = 0;
  localparam int SR4_RX_MF    = 1;
  localparam int SR4_TX_ALIGN = 3;
  localparam int SR4_TX_MF    = 4;

  // -----------------------------------------------------------------
  // time slot 0 layout and multiframe geometry
  // -----------------------------------------------------------------
  localparam int       SI_POS      = 7;     // si bit, first bit of ts0
  localparam int       SA_HI       = 4;     // sa4 .. sa8 at bits 4..0
  localparam int       SA_OVR_LO   = 3;     // e1_tx_control_two bits 3..7
  localparam int       SA_OVR_HI   = 7;
  localparam int       NUM_GRP     = 8;
  localparam int       GRP_W       = 8;
  localparam logic [3:0] MF_LAST   = 4'hF;  // 16 frames per crc4 multiframe
  localparam logic [3:0] MF_FIRST  = 4'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // ts0 bit carried by each multiframe group: si(af), si(naf), a, sa4..sa8
  localparam int GRP_POS [NUM_GRP] = '{7, 7, 5, 4, 3, 2, 1, 0};

  // -----------------------------------------------------------------
  // carriers
  // -----------------------------------------------------------------
  typedef struct packed {
    logic       valid;     // one-cycle strobe, one per frame
    logic       align;     // 1 = frame holds the alignment word
    logic       mf_start;  // first frame of a crc4 multiframe
    logic [7:0] bits;      // time slot 0 byte, msb first on line
  } ts0_frame_s;

  typedef logic [NUM_GRP-1:0][GRP_W-1:0] ovh_set_t;
endpackage

// shifts one overhead bit per selected frame and captures the byte whole
module ovh_shift_cap #(
  parameter int W = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_shift_en,
  input  wire logic         i_bit_in,
  input  wire logic         i_cap_en,
  output logic [W-1:0]      o_cap
);
  logic [W-1:0] sh_reg;
  logic [W-1:0] sh_next;

  // earliest bit ends up in the msb after W shifts
  assign sh_next = {sh_reg[W-2:0], i_bit_in};

  // -----------------------------------------------------------------
  // shift and whole-byte capture
  // -----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sh_reg <= '0;
    end else if (i_shift_en) begin
      sh_reg <= sh_next;
    end
  end

  // capture may coincide with the last shift, so take the shifted value then
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cap <= '0;
    end else if (i_cap_en) begin
      o_cap <= i_shift_en ? sh_next : sh_reg;
    end
  end
endmodule

// *** e1_spare_bit_access.sv ***
// e1 sa/si overhead bit access: double-frame and crc4 multiframe register schemes
`timescale 1ns/100ps

module e1_spare_bit_access
  import e1_sa_pkg::*;
(
  input  wire logic       I_REF_CLK,
  input  wire logic       I_SYS_RST,
  input  wire logic       I_E1_MODE,
  input  wire logic       I_CRC4_EN,
  input  wire logic       I_AUTO_EBIT_EN,
  input  wire logic       I_SI_FROM_TX_SERIAL_DATA_IN,
  input  wire logic [7:0] I_E1_TX_CONTROL_TWO,
  input  wire logic [7:0] I_TX_SPARE_BIT_CONTROL,
  input  wire ts0_frame_s I_RX_FRAME,
  input  wire ts0_frame_s I_TX_REQ,
  input  wire logic [7:0] I_TX_ALIGN_FRAME_BITS,
  input  wire logic [7:0] I_TX_NONALIGN_FRAME_BITS,
  input  wire ovh_set_t   I_TX_MF_REGS,
  output logic [7:0]      O_RX_ALIGN_FRAME_BITS,
  output logic [7:0]      O_RX_NONALIGN_FRAME_BITS,
  output ovh_set_t        O_RX_MF_REGS,
  output logic [7:0]      O_FRAMING_STATUS_FOUR,
  output logic [7:0]      O_TX_TS0,
  output logic            O_TX_TS0_VALID
);
  // -----------------------------------------------------------------
  // qualified strobes and frame positions
  // -----------------------------------------------------------------
  logic       rx_go;
  logic       tx_go;
  logic [3:0] rx_cnt_reg;
  logic [3:0] rx_idx;
  logic [3:0] tx_cnt_reg;
  logic [3:0] tx_idx;
  logic [7:0] rx_af_shadow_reg;
  logic [7:0] tx_naf_hold_reg;
  ovh_set_t   tx_mf_hold_reg;
  ovh_set_t   tx_mf_set;
  logic       si_ovr;
  logic       sa_ovr;
  logic [7:0] tx_next;
  logic [7:0] status_next;
  logic [2:0] bit_sel;

  // outside e1 operation only the tx ts0 output and its valid still follow each request
  assign rx_go  = I_RX_FRAME.valid & I_E1_MODE;
  assign tx_go  = I_TX_REQ.valid & I_E1_MODE;
  assign rx_idx = I_RX_FRAME.mf_start ? MF_FIRST : rx_cnt_reg;
  assign tx_idx = I_TX_REQ.mf_start ? MF_FIRST : tx_cnt_reg;
  assign si_ovr = I_SI_FROM_TX_SERIAL_DATA_IN | I_CRC4_EN | I_AUTO_EBIT_EN;
  assign sa_ovr = |I_E1_TX_CONTROL_TWO[SA_OVR_HI:SA_OVR_LO];

  // frame counters restart on the multiframe marker from the framer
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      rx_cnt_reg <= MF_FIRST;
    end else if (rx_go) begin
      rx_cnt_reg <= rx_idx + 4'h1;
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      tx_cnt_reg <= MF_FIRST;
    end else if (tx_go) begin
      tx_cnt_reg <= tx_idx + 4'h1;
    end
  end

  // -----------------------------------------------------------------
  // receive double-frame capture
  // -----------------------------------------------------------------
  // align byte waits in a shadow so both registers change in one edge
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      rx_af_shadow_reg <= BYTE_ZERO;
    end else if (rx_go && I_RX_FRAME.align) begin
      rx_af_shadow_reg <= I_RX_FRAME.bits;
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_RX_ALIGN_FRAME_BITS    <= BYTE_ZERO;
      O_RX_NONALIGN_FRAME_BITS <= BYTE_ZERO;
    end else if (rx_go && !I_RX_FRAME.align) begin
      O_RX_ALIGN_FRAME_BITS    <= rx_af_shadow_reg;
      O_RX_NONALIGN_FRAME_BITS <= I_RX_FRAME.bits;
    end
  end

  // -----------------------------------------------------------------
  // receive multiframe groups
  // -----------------------------------------------------------------
  // group 0 collects align-frame si, the rest come from nonalign frames
  for (genvar g = 0; g < NUM_GRP; g++) begin : g_rx_grp
    ovh_shift_cap #(
      .W (GRP_W)
    ) u_cap (
      .i_clk      (I_REF_CLK),
      .i_rst      (I_SYS_RST),
      .i_shift_en (rx_go && (I_RX_FRAME.align == (g == 0))),
      .i_bit_in   (I_RX_FRAME.bits[GRP_POS[g]]),
      .i_cap_en   (rx_go && (rx_idx == MF_LAST)),
      .o_cap      (O_RX_MF_REGS[g])
    );
  end

  // -----------------------------------------------------------------
  // transmit sampling
  // -----------------------------------------------------------------
  // the align frame uses the live register, the nonalign its held copy
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      tx_naf_hold_reg <= BYTE_ZERO;
    end else if (tx_go && I_TX_REQ.align) begin
      tx_naf_hold_reg <= I_TX_NONALIGN_FRAME_BITS;
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      tx_mf_hold_reg <= '0;
    end else if (tx_go && I_TX_REQ.mf_start) begin
      tx_mf_hold_reg <= I_TX_MF_REGS;
    end
  end

  assign tx_mf_set = I_TX_REQ.mf_start ? I_TX_MF_REGS : tx_mf_hold_reg;
  // align/nonalign pairs advance one bit per double frame, msb first
  assign bit_sel   = 3'h7 - tx_idx[3:1];

  // -----------------------------------------------------------------
  // transmit ts0 composition
  // -----------------------------------------------------------------
  // priority: framer overrides over multiframe groups over double-frame
  always_comb begin
    tx_next = I_TX_REQ.bits;
    if (I_E1_MODE) begin
      if (I_TX_REQ.align) begin
        tx_next = I_TX_ALIGN_FRAME_BITS;
        if (I_TX_SPARE_BIT_CONTROL[0]) begin
          tx_next[SI_POS] = tx_mf_set[0][bit_sel];
        end
      end else begin
        tx_next = tx_naf_hold_reg;
        for (int g = 1; g < NUM_GRP; g++) begin
          if (I_TX_SPARE_BIT_CONTROL[g]) begin
            tx_next[GRP_POS[g]] = tx_mf_set[g][bit_sel];
          end
        end
        if (sa_ovr) begin
          tx_next[SA_HI:0] = I_TX_REQ.bits[SA_HI:0];
        end
      end
      if (si_ovr) begin
        tx_next[SI_POS] = I_TX_REQ.bits[SI_POS];
      end
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_TX_TS0       <= BYTE_ZERO;
      O_TX_TS0_VALID <= 1'b0;
    end else begin
      O_TX_TS0_VALID <= I_TX_REQ.valid;
      if (I_TX_REQ.valid) begin
        O_TX_TS0 <= tx_next;
      end
    end
  end

  // -----------------------------------------------------------------
  // status pulses
  // -----------------------------------------------------------------
  // no host clear path exists here, so each event is a one-cycle pulse
  always_comb begin
    status_next               = BYTE_ZERO;
    status_next[SR4_RX_ALIGN] = rx_go && !I_RX_FRAME.align;
    status_next[SR4_RX_MF]    = rx_go && (rx_idx == MF_LAST);
    status_next[SR4_TX_ALIGN] = tx_go && I_TX_REQ.align;
    status_next[SR4_TX_MF]    = tx_go && I_TX_REQ.mf_start;
  end

  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_FRAMING_STATUS_FOUR <= BYTE_ZERO;
    end else begin
      O_FRAMING_STATUS_FOUR <= status_next;
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_SYS_RST);

  a_t1_no_flags: assert property (
    !I_E1_MODE && $stable(I_E1_MODE) |=> O_FRAMING_STATUS_FOUR == BYTE_ZERO)
    else $error("status pulse outside e1 mode");
  a_t1_pass_through: assert property (
    I_TX_REQ.valid && !I_E1_MODE |=> O_TX_TS0 == $past(I_TX_REQ.bits))
    else $error("t1 ts0 byte altered");
  a_rx_df_load: assert property (
    rx_go && !I_RX_FRAME.align |=> O_RX_NONALIGN_FRAME_BITS == $past(I_RX_FRAME.bits)
      && O_RX_ALIGN_FRAME_BITS == $past(rx_af_shadow_reg))
    else $error("double-frame capture wrong");
  a_rx_df_flag: assert property (
    O_FRAMING_STATUS_FOUR[SR4_RX_ALIGN] == $past(rx_go && !I_RX_FRAME.align))
    else $error("rx align flag does not match refresh");
  a_tx_df_flag: assert property (
    tx_go && I_TX_REQ.align |=> O_FRAMING_STATUS_FOUR[SR4_TX_ALIGN] && O_TX_TS0_VALID)
    else $error("tx align flag missing");
  a_tx_fas_hold: assert property (
    tx_go && I_TX_REQ.align |=> O_TX_TS0[6:0] == $past(I_TX_ALIGN_FRAME_BITS[6:0]))
    else $error("align register bits not sent");
  a_tx_si_over: assert property (
    tx_go && si_ovr |=> O_TX_TS0[SI_POS] == $past(I_TX_REQ.bits[SI_POS]))
    else $error("si override ignored");
  a_tx_sa_over: assert property (
    tx_go && !I_TX_REQ.align && sa_ovr |=> O_TX_TS0[SA_HI:0] == $past(I_TX_REQ.bits[SA_HI:0]))
    else $error("sa override ignored");
  a_rx_mf_flag: assert property (
    rx_go && rx_idx == MF_LAST |=> O_FRAMING_STATUS_FOUR[SR4_RX_MF] ##1 !O_FRAMING_STATUS_FOUR[SR4_RX_MF])
    else $error("rx multiframe flag wrong");
  a_tx_mf_flag: assert property (
    tx_go && I_TX_REQ.mf_start |=> O_FRAMING_STATUS_FOUR[SR4_TX_MF])
    else $error("tx multiframe flag missing");
  a_tx_mf_msb: assert property (
    tx_go && I_TX_REQ.mf_start && I_TX_REQ.align && I_TX_SPARE_BIT_CONTROL[0] && !si_ovr
      |=> O_TX_TS0[SI_POS] == $past(I_TX_MF_REGS[0][7]))
    else $error("multiframe msb not first");

  c_rx_mf_done: cover property (rx_go && rx_idx == MF_LAST);
  c_tx_mf_insert: cover property (tx_go && I_TX_REQ.mf_start && |I_TX_SPARE_BIT_CONTROL);
  c_sa_override: cover property (tx_go && !I_TX_REQ.align && sa_ovr);
endmodule

// *** framer_model.sv ***
// framer datapath model: issues time slot 0 strobes for receive and transmit
`timescale 1ns/100ps

module framer_model
  import e1_sa_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_stall,
  input  wire logic [7:0] i_rx_byte,
  input  wire logic [7:0] i_tx_byte,
  output ts0_frame_s      o_rx,
  output ts0_frame_s      o_tx,
  output logic            o_mf_last
);
  logic [3:0] idx_reg;

  // one frame per unstalled cycle; even frames carry the alignment word
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      idx_reg   <= MF_FIRST;
      o_rx      <= '0;
      o_tx      <= '0;
      o_mf_last <= 1'b0;
    end else if (i_stall) begin
      // idle bytes flip so a stale value never looks valid
      o_rx.valid <= 1'b0;
      o_tx.valid <= 1'b0;
      o_rx.bits  <= ~o_rx.bits;
      o_tx.bits  <= ~o_tx.bits;
      o_mf_last  <= 1'b0;
    end else begin
      o_rx      <= '{1'b1, ~idx_reg[0], idx_reg == MF_FIRST, i_rx_byte};
      o_tx      <= '{1'b1, ~idx_reg[0], idx_reg == MF_FIRST, i_tx_byte};
      o_mf_last <= (idx_reg == MF_LAST);
      idx_reg   <= idx_reg + 4'h1;
    end
  end
endmodule

// *** tb_top.sv ***
// self-checking bench for the e1 sa/si overhead bit access block
`timescale 1ns/100ps

`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp=%0h got=%0h", nm, e, g); end end

module tb_top;
  import e1_sa_pkg::*;
  // -----------------------------------------------------------------
  // signals
  // -----------------------------------------------------------------
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        stl = 1'b0;
  logic        mfl;
  logic [7:0]  rxb = 8'h00, txb = 8'h00;
  logic [7:0]  ta = 8'h1B, tn = 8'h40;
  logic [19:0] cfg;      // mode, crc4, auto e, serial si, control two, spare control
  ovh_set_t    tmf = '0;
  ts0_frame_s  rx, tx;
  logic [7:0]  o_ra, o_rn, o_st, o_ts;
  logic        o_tv;
  ovh_set_t    o_mf;
  int          n_mismatch = 0, comparisons = 0, cyc = 0, m;
  logic [19:0] tbl [4] = '{20'h80000, 20'h800FF, 20'hFF8FF, 20'h7F8FF};

  framer_model PART (.i_clk(clk), .i_rst(rst), .i_stall(stl), .i_rx_byte(rxb),
    .i_tx_byte(txb), .o_rx(rx), .o_tx(tx), .o_mf_last(mfl));

  e1_spare_bit_access DUT (.I_REF_CLK(clk), .I_SYS_RST(rst), .I_E1_MODE(cfg[19]),
    .I_CRC4_EN(cfg[18]), .I_AUTO_EBIT_EN(cfg[17]), .I_SI_FROM_TX_SERIAL_DATA_IN(cfg[16]),
    .I_E1_TX_CONTROL_TWO(cfg[15:8]), .I_TX_SPARE_BIT_CONTROL(cfg[7:0]), .I_RX_FRAME(rx),
    .I_TX_REQ(tx), .I_TX_ALIGN_FRAME_BITS(ta), .I_TX_NONALIGN_FRAME_BITS(tn),
    .I_TX_MF_REGS(tmf), .O_RX_ALIGN_FRAME_BITS(o_ra), .O_RX_NONALIGN_FRAME_BITS(o_rn),
    .O_RX_MF_REGS(o_mf), .O_FRAMING_STATUS_FOUR(o_st), .O_TX_TS0(o_ts), .O_TX_TS0_VALID(o_tv));

  initial forever #10 clk = ~clk;

  // -----------------------------------------------------------------
  // stimulus: random bytes and stalls; host rewrites only after flags
  // -----------------------------------------------------------------
  always @(posedge clk) begin
    rxb <= 8'($urandom);
    txb <= 8'($urandom);
    stl <= ($urandom % 4) == 0;
    // skipping a rewrite leaves the held values to be sent again
    if (o_st[3] === 1'b1 && $urandom % 2) begin
      ta <= 8'($urandom);
      tn <= 8'($urandom);
    end
    if (o_st[4] === 1'b1 && $urandom % 2) tmf <= {$urandom, $urandom};
  end

  // -----------------------------------------------------------------
  // reference model, worked from the values taken at each edge
  // -----------------------------------------------------------------
  logic [7:0] e_ra, e_rn, e_st, e_ts, shd, nal, b;
  logic       e_tv;
  logic [3:0] ri, ti;
  ovh_set_t   e_mf, sh, mfl_q, mf;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      {e_ra, e_rn, e_st, e_ts, shd, nal, e_tv, ri, ti} = '0;
      {e_mf, sh, mfl_q} = '0;
    end else begin
      e_st = 8'h00;
      e_tv = 1'b0;
      if (rx.valid && cfg[19]) begin
        ri = rx.mf_start ? MF_FIRST : ri + 4'h1;
        if (rx.align) begin
          shd = rx.bits;
          sh[0] = {sh[0][6:0], rx.bits[7]};
        end else begin
          {e_ra, e_rn} = {shd, rx.bits};
          e_st[SR4_RX_ALIGN] = 1'b1;
          for (int g = 1; g < NUM_GRP; g++) sh[g] = {sh[g][6:0], rx.bits[GRP_POS[g]]};
        end
        if (ri == MF_LAST) begin
          e_mf = sh;
          e_st[SR4_RX_MF] = 1'b1;
        end
      end
      if (tx.valid) begin
        e_tv = 1'b1;
        b = tx.bits;
        if (cfg[19]) begin
          ti = tx.mf_start ? MF_FIRST : ti + 4'h1;
          if (tx.mf_start) mfl_q = tmf;
          mf = tx.mf_start ? tmf : mfl_q;
          e_st[SR4_TX_MF] = tx.mf_start;
          if (tx.align) begin
            {b, nal} = {ta, tn};
            e_st[SR4_TX_ALIGN] = 1'b1;
            if (cfg[0]) b[7] = mf[0][3'd7 - ti[3:1]];
          end else begin
            b = nal;
            for (int g = 1; g < NUM_GRP; g++) if (cfg[g]) b[GRP_POS[g]] = mf[g][3'd7 - ti[3:1]];
            if (|cfg[15:11]) b[4:0] = tx.bits[4:0];
          end
          if (|cfg[18:16]) b[7] = tx.bits[7];
        end
        e_ts = b;
      end
    end
  end

  // outputs compared mid-cycle, after the edge has settled
  always @(negedge clk) begin
    if (!rst) begin
      `CHK("status", e_st, o_st)
      `CHK("rx_align", e_ra, o_ra)
      `CHK("rx_nonalign", e_rn, o_rn)
      `CHK("rx_mf", e_mf, o_mf)
      `CHK("tx_valid", e_tv, o_tv)
      `CHK("tx_ts0", e_ts, o_ts)
    end
  end

  task automatic summarize();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // hang guard: the run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      summarize();
    end
  end

  // -----------------------------------------------------------------
  // main sequence: corner configs first, then random, one per multiframe
  // -----------------------------------------------------------------
  initial begin
    void'($urandom(71856));
    cfg = tbl[0];
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (m = 1; m < 30; m++) begin
      do @(posedge clk); while (mfl !== 1'b1);
      cfg <= (m < 4) ? tbl[m] : 20'($urandom | ((m % 5) ? 32'h00080000 : 32'h00000000));
    end
    do @(posedge clk); while (mfl !== 1'b1);
    repeat (3) @(posedge clk);
    summarize();
  end
endmodule
